// ### phy_mmd_registers.v
/*
 * Management register bank for the PMA/PMD, PCS and auto-negotiation devices
 * of a multi-rate copper transceiver.
 * Assumes a management frame decoder in front that delivers one-cycle read and
 * write strobes with device number and register address; status inputs are
 * synchronous to clk_sys.
 */
// Summary of operation
// [RL1] vendor bit set: partner-info-valid latches high until read; else live value.
// [RL2] partner and local backoff codes shown in 15:13 and 12:10, 2 dB steps.
// [RL3] test select 15:13 picks normal operation or transmitter test modes 1..7.
// [RL4] test frequency 12:10 applied only in test mode 4; reserved codes ignored.
// [RL5] pair B, C, D skew shown read-only as 7-bit fields.
// [RL6] two 5-bit counts of partner and local fast retrain events.
// [RL7] 2-bit selector chooses idle, local fault or link interruption during retrain.
// [RL8] fast retrain enable bit, reset value 1.
// [RL9] read-only bit 3 shows fast retrain was negotiated.
// [RL10] PCS reset bit restores all three devices, then clears itself.
// [RL11] PCS loopback active while control bit 14 is 1.
// [RL12] transmit and receive low power idle flags latch high until read.
// [RL13] bits 9 and 8 show live low power idle state.
// [RL14] PCS receive link bit latches low until read.
// [RL15] 16-bit clear-on-read counter of failed wake attempts.
// [RL16] AN reset bit restores all three devices, then clears itself.
// [RL17] extended next page control ignored while advertisement bit 12 is 0.
// [RL18] AN runs while enable bit 12 is 1; self-clearing bit 9 restarts it.
// [RL19] page-received bit 6 sets on a page and holds until read.
// [RL20] bit 5 AN complete, bit 2 latched-low link, bit 4 remote fault.
// [RL21] fixed ability bits: 2.5G, 10, 100, 1000 yes; 5G, 10G, backplane no.
// [RL22] EEE capability bits 2 and 1 read as constant 1.
// [RL23] a read of a latched flag reloads it from the present condition.
`timescale 1ns/1ps
`include "phy_mmd_map.vh"

module phy_mmd_registers #(
  parameter RETRAIN_CNT_W = 5,
  parameter WAKE_CNT_W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire [4:0] mmd_sel,
  input wire [15:0] reg_addr,
  input wire [15:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rd_data,
  output reg rd_valid,
  input wire partner_info_live,
  input wire [2:0] partner_backoff_code,
  input wire [2:0] local_backoff_code,
  input wire [3:0] polarity_flags,
  input wire [1:0] mdi_connection,
  input wire [6:0] skew_b,
  input wire [6:0] skew_c,
  input wire [6:0] skew_d,
  input wire partner_retrain_evt,
  input wire local_retrain_evt,
  input wire quick_retrain_agreed,
  input wire tx_lpi_live,
  input wire rx_lpi_live,
  input wire pcs_link_live,
  input wire wake_fault_evt,
  input wire page_rx_evt,
  input wire negotiation_done,
  input wire remote_fault_live,
  input wire an_link_live,
  input wire adv_next_page_able,
  output wire [2:0] transmitter_test_select,
  output wire [2:0] test_tone_select,
  output wire [1:0] retrain_signal_kind,
  output wire quick_retrain_allow,
  output wire pcs_loopback,
  output wire negotiation_enable,
  output reg negotiation_restart,
  output wire xnp_active,
  output reg bank_reset_pulse
);

  reg [2:0] test_sel_q;
  reg [2:0] test_freq_q;
  reg [1:0] sigkind_q;
  reg retrain_en_q;
  reg lh_enable_q;
  reg loopback_q;
  reg xnp_q;
  reg an_en_q;
  reg info_flag_q;
  reg tx_lpi_flag_q;
  reg rx_lpi_flag_q;
  reg pcs_link_flag_q;
  reg page_flag_q;
  reg an_link_flag_q;
  reg [RETRAIN_CNT_W-1:0] partner_retrain_count_q;
  reg [RETRAIN_CNT_W-1:0] local_retrain_count_q;
  reg [WAKE_CNT_W-1:0] wake_count_q;

  wire sel_pma = (mmd_sel == `DEV_PMA);
  wire sel_pcs = (mmd_sel == `DEV_PCS);
  wire sel_an = (mmd_sel == `DEV_AN);

  wire wr_test = wr_stb && sel_pma && (reg_addr == `TEST_CTRL_OFS);
  wire wr_retrain = wr_stb && sel_pma && (reg_addr == `RETRAIN_OFS);
  wire wr_vendor = wr_stb && sel_pma && (reg_addr == `VENDOR_CTRL_OFS);
  wire wr_pcs_ctrl = wr_stb && sel_pcs && (reg_addr == `PCS_CTRL_OFS);
  wire wr_an_ctrl = wr_stb && sel_an && (reg_addr == `AN_CTRL_OFS);

  wire rd_info = rd_stb && sel_pma && (reg_addr == `PARTNER_INFO_OFS);
  wire rd_pcs_stat = rd_stb && sel_pcs && (reg_addr == `PCS_STAT_OFS);
  wire rd_wake = rd_stb && sel_pcs && (reg_addr == `WAKE_ERR_OFS);
  wire rd_an_stat = rd_stb && sel_an && (reg_addr == `AN_STAT_OFS);

  // a reset request from either device resets the whole bank
  wire soft_reset = (wr_pcs_ctrl && wr_data[`RESET_BIT]) || // RL10
                    (wr_an_ctrl && wr_data[`RESET_BIT]); // RL16

  // control registers; soft reset wins over a write in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_sel_q <= 3'h0;
      test_freq_q <= 3'h0;
      sigkind_q <= 2'h0;
      retrain_en_q <= `RETRAIN_EN_RST;
      lh_enable_q <= `LH_ENABLE_RST;
      loopback_q <= 1'b0;
      xnp_q <= `XNP_RST;
      an_en_q <= 1'b0;
    end else if (soft_reset) begin
      test_sel_q <= 3'h0; // RL10 RL16
      test_freq_q <= 3'h0;
      sigkind_q <= 2'h0;
      retrain_en_q <= `RETRAIN_EN_RST;
      lh_enable_q <= `LH_ENABLE_RST;
      loopback_q <= 1'b0;
      xnp_q <= `XNP_RST;
      an_en_q <= 1'b0;
    end else begin
      if (wr_test) begin
        test_sel_q <= wr_data[`TEST_SEL_HI:`TEST_SEL_LO]; // RL3
        test_freq_q <= wr_data[`TEST_FREQ_HI:`TEST_FREQ_LO]; // RL4
      end
      if (wr_retrain) begin
        sigkind_q <= wr_data[`SIGKIND_HI:`SIGKIND_LO]; // RL7
        retrain_en_q <= wr_data[`RETRAIN_EN_BIT]; // RL8
      end
      if (wr_vendor)
        lh_enable_q <= wr_data[`LH_ENABLE_BIT];
      if (wr_pcs_ctrl)
        loopback_q <= wr_data[`LOOPBACK_BIT]; // RL11
      if (wr_an_ctrl) begin
        xnp_q <= wr_data[`XNP_BIT];
        an_en_q <= wr_data[`AN_EN_BIT]; // RL18
      end
    end
  end

  // restart and reset are pulses, so their bits always read back as 0
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      negotiation_restart <= 1'b0;
      bank_reset_pulse <= 1'b0;
    end else begin
      negotiation_restart <= wr_an_ctrl && wr_data[`AN_RESTART_BIT] && !soft_reset; // RL18
      bank_reset_pulse <= soft_reset; // RL10 RL16
    end
  end

  // latched flags: an event sets a latched-high flag, a lost link clears a latched-low one, a read reloads from the present condition
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      info_flag_q <= 1'b0;
      tx_lpi_flag_q <= 1'b0;
      rx_lpi_flag_q <= 1'b0;
      pcs_link_flag_q <= 1'b0;
      page_flag_q <= 1'b0;
      an_link_flag_q <= 1'b0;
    end else if (soft_reset) begin
      info_flag_q <= 1'b0;
      tx_lpi_flag_q <= 1'b0;
      rx_lpi_flag_q <= 1'b0;
      pcs_link_flag_q <= 1'b0;
      page_flag_q <= 1'b0;
      an_link_flag_q <= 1'b0;
    end else begin
      info_flag_q <= partner_info_live | (info_flag_q & ~rd_info); // RL1 RL23
      tx_lpi_flag_q <= tx_lpi_live | (tx_lpi_flag_q & ~rd_pcs_stat); // RL12 RL23
      rx_lpi_flag_q <= rx_lpi_live | (rx_lpi_flag_q & ~rd_pcs_stat); // RL12 RL23
      pcs_link_flag_q <= pcs_link_live & (pcs_link_flag_q | rd_pcs_stat); // RL14 RL23
      page_flag_q <= page_rx_evt | (page_flag_q & ~rd_an_stat); // RL19 RL23
      an_link_flag_q <= an_link_live & (an_link_flag_q | rd_an_stat); // RL20 RL23
    end
  end

  // retrain counters roll over; wake counter saturates and clears on read
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      partner_retrain_count_q <= {RETRAIN_CNT_W{1'b0}};
      local_retrain_count_q <= {RETRAIN_CNT_W{1'b0}};
      wake_count_q <= {WAKE_CNT_W{1'b0}};
    end else if (soft_reset) begin
      partner_retrain_count_q <= {RETRAIN_CNT_W{1'b0}};
      local_retrain_count_q <= {RETRAIN_CNT_W{1'b0}};
      wake_count_q <= {WAKE_CNT_W{1'b0}};
    end else begin
      if (partner_retrain_evt)
        partner_retrain_count_q <= partner_retrain_count_q + 1'b1; // RL6
      if (local_retrain_evt)
        local_retrain_count_q <= local_retrain_count_q + 1'b1; // RL6
      // an event in the read cycle is kept as a count of one
      if (rd_wake)
        wake_count_q <= {{(WAKE_CNT_W-1){1'b0}}, wake_fault_evt}; // RL15
      else if (wake_fault_evt && !(&wake_count_q))
        wake_count_q <= wake_count_q + 1'b1; // RL15
    end
  end

  // read multiplexer, answered one cycle after the strobe
  reg [15:0] read_mux;
  always @* begin
    read_mux = 16'h0000;
    if (sel_pma) begin
      case (reg_addr)
        `PMA_EXT_ABILITY_OFS: read_mux = `PMA_EXT_ABILITY_VAL; // RL21
        `PMA_MULTIRATE_OFS: read_mux = `PMA_MULTIRATE_VAL; // RL21
        `PARTNER_INFO_OFS: read_mux = {15'h0000, lh_enable_q ? info_flag_q : partner_info_live}; // RL1
        `PAIR_SWAP_OFS: read_mux = {4'h0, polarity_flags, 6'h00, mdi_connection};
        `BACKOFF_OFS: read_mux = {partner_backoff_code, local_backoff_code, 10'h000}; // RL2
        `TEST_CTRL_OFS: read_mux = {test_sel_q, test_freq_q, 10'h000};
        `SKEW_B_OFS: read_mux = {1'b0, skew_b, 8'h00}; // RL5
        `SKEW_CD_OFS: read_mux = {1'b0, skew_d, 1'b0, skew_c}; // RL5
        `RETRAIN_OFS: read_mux = {partner_retrain_count_q, local_retrain_count_q, 6'h00} |
                                 `RETRAIN_FIXED |
                                 {12'h000, quick_retrain_agreed, sigkind_q, retrain_en_q}; // RL6 RL9
        `VENDOR_CTRL_OFS: read_mux = {15'h0000, lh_enable_q};
        default: read_mux = 16'h0000;
      endcase
    end else if (sel_pcs) begin
      case (reg_addr)
        `PCS_CTRL_OFS: read_mux = `PCS_CTRL_FIXED | {1'b0, loopback_q, 14'h0000};
        `PCS_STAT_OFS: read_mux = {4'h0, tx_lpi_flag_q, rx_lpi_flag_q, tx_lpi_live, rx_lpi_live,
                                   5'h00, pcs_link_flag_q, 2'h0}; // RL12 RL13 RL14
        `PCS_SPEED_OFS: read_mux = `PCS_SPEED_VAL;
        `EEE_CAP_OFS: read_mux = `EEE_CAP_VAL; // RL22
        `EEE_CAP2_OFS: read_mux = `EEE_CAP2_VAL;
        `WAKE_ERR_OFS: read_mux = wake_count_q; // RL15
        default: read_mux = 16'h0000;
      endcase
    end else if (sel_an) begin
      case (reg_addr)
        `AN_CTRL_OFS: read_mux = {2'h0, xnp_q, an_en_q, 12'h000};
        `AN_STAT_OFS: read_mux = `AN_STAT_FIXED |
                                 {9'h000, page_flag_q, negotiation_done, remote_fault_live,
                                  1'b0, an_link_flag_q, 2'h0}; // RL19 RL20
        default: read_mux = 16'h0000;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb)
        rd_data <= read_mux;
    end
  end

  assign transmitter_test_select = test_sel_q; // RL3
  // tone codes 0, 3 and 7 are reserved and never reach the transmitter
  assign test_tone_select = (test_sel_q == `TEST_MODE_DISTORTION &&
                             test_freq_q != 3'h0 && test_freq_q != 3'h3 &&
                             test_freq_q != 3'h7) ? test_freq_q : 3'h0; // RL4
  assign retrain_signal_kind = sigkind_q; // RL7
  assign quick_retrain_allow = retrain_en_q; // RL8
  assign pcs_loopback = loopback_q; // RL11
  assign negotiation_enable = an_en_q; // RL18
  assign xnp_active = xnp_q && adv_next_page_able; // RL17

endmodule

// ### phy_mmd_map.vh
/*
 * Register map of the management-visible device bank: device numbers,
 * register offsets, field positions, reset values and fixed ability words.
 * Assumes inclusion by the bank module only; definitions only.
 */
`ifndef PHY_MMD_MAP_VH
`define PHY_MMD_MAP_VH

`define DEV_PMA 5'h01
`define DEV_PCS 5'h03
`define DEV_AN 5'h07

`define PMA_EXT_ABILITY_OFS 16'h000b
`define PMA_MULTIRATE_OFS 16'h0015
`define PARTNER_INFO_OFS 16'h0081
`define PAIR_SWAP_OFS 16'h0082
`define BACKOFF_OFS 16'h0083
`define TEST_CTRL_OFS 16'h0084
`define SKEW_B_OFS 16'h0091
`define SKEW_CD_OFS 16'h0092
`define RETRAIN_OFS 16'h0093
`define VENDOR_CTRL_OFS 16'h8000

`define PCS_CTRL_OFS 16'h0000
`define PCS_STAT_OFS 16'h0001
`define PCS_SPEED_OFS 16'h0004
`define EEE_CAP_OFS 16'h0014
`define EEE_CAP2_OFS 16'h0015
`define WAKE_ERR_OFS 16'h0016

`define AN_CTRL_OFS 16'h0000
`define AN_STAT_OFS 16'h0001

`define PMA_EXT_ABILITY_VAL 16'h41a0
`define PMA_MULTIRATE_VAL 16'h0001
`define PCS_SPEED_VAL 16'h0040
`define EEE_CAP_VAL 16'h0006
`define EEE_CAP2_VAL 16'h0001
`define PCS_CTRL_FIXED 16'h205c
`define RETRAIN_FIXED 16'h0010
`define AN_STAT_FIXED 16'h0008

`define RESET_BIT 15
`define LOOPBACK_BIT 14
`define XNP_BIT 13
`define AN_EN_BIT 12
`define AN_RESTART_BIT 9
`define TEST_SEL_HI 15
`define TEST_SEL_LO 13
`define TEST_FREQ_HI 12
`define TEST_FREQ_LO 10
`define SIGKIND_HI 2
`define SIGKIND_LO 1
`define RETRAIN_EN_BIT 0
`define LH_ENABLE_BIT 0

`define RETRAIN_EN_RST 1'b1
`define XNP_RST 1'b1
`define LH_ENABLE_RST 1'b0

`define TEST_MODE_DISTORTION 3'h4

`endif

// ### mgmt_host.sv
/* Management host model: one strobe access per task call.
   Assumes the bank answers a read on the next edge. */
`timescale 1ns/1ps
module mgmt_host (
  input wire clk_sys,
  output logic [4:0] mmd_sel = 5'h00,
  output logic [15:0] reg_addr = 16'h0000,
  output logic [15:0] wr_data = 16'h0000,
  output logic wr_stb = 1'b0,
  output logic rd_stb = 1'b0,
  input wire [15:0] rd_data,
  input wire rd_valid
);
  task automatic wr(input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    mmd_sel <= d;
    reg_addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    // released data must not look held
    wr_data <= ~v;
    #1;
  endtask
  task automatic rd(input logic [4:0] d, input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    mmd_sel <= d;
    reg_addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    v = rd_valid ? rd_data : 16'hxxxx;
  endtask
endmodule

// ### phy_mmd_properties.sv
/* Checker of the bank's control outputs.
   Bound to phy_mmd_registers; rst async high. */
`timescale 1ns/1ps
module phy_mmd_checker (
  input wire clk_sys,
  input wire rst,
  input wire [4:0] mmd_sel,
  input wire [15:0] reg_addr,
  input wire [15:0] wr_data,
  input wire wr_stb,
  input wire [2:0] transmitter_test_select,
  input wire [2:0] test_tone_select,
  input wire quick_retrain_allow,
  input wire pcs_loopback,
  input wire negotiation_enable,
  input wire negotiation_restart,
  input wire xnp_active,
  input wire adv_next_page_able,
  input wire bank_reset_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire pw = wr_stb && mmd_sel == 5'h01;
  wire cw = wr_stb && mmd_sel == 5'h03 && reg_addr == 16'h0000;
  wire aw = wr_stb && mmd_sel == 5'h07 && reg_addr == 16'h0000;
  wire sr = (cw || aw) && wr_data[15];
  a_test_select: assert property (pw && reg_addr == 16'h0084 |=>
    transmitter_test_select == $past(wr_data[15:13])) else $error("test select");
  a_tone_gate: assert property (test_tone_select != 3'h0 |-> transmitter_test_select == 3'h4 &&
    test_tone_select != 3'h3 && test_tone_select != 3'h7) else $error("tone gate");
  a_loopback_bit: assert property (cw && !sr |=> pcs_loopback == $past(wr_data[14]))
    else $error("loopback");
  a_retrain_enable: assert property (pw && reg_addr == 16'h0093 |=>
    quick_retrain_allow == $past(wr_data[0])) else $error("retrain enable");
  a_an_enable: assert property (aw && !sr |=> negotiation_enable == $past(wr_data[12]))
    else $error("an enable");
  a_restart_pulse: assert property (aw && !sr && wr_data[9] |=> negotiation_restart ##1
    !negotiation_restart) else $error("restart pulse");
  a_soft_reset: assert property (sr |=> bank_reset_pulse && !pcs_loopback && !negotiation_enable
    && quick_retrain_allow && transmitter_test_select == 3'h0) else $error("soft reset");
  a_xnp_gate: assert property (!adv_next_page_able |-> !xnp_active) else $error("xnp gate");
  c_soft: cover property (sr);
  c_restart: cover property (negotiation_restart);
  c_tone: cover property (test_tone_select != 3'h0);
endmodule
bind phy_mmd_registers phy_mmd_checker phy_mmd_checker_i (.clk_sys, .rst, .mmd_sel, .reg_addr, .wr_data,
  .wr_stb, .transmitter_test_select, .test_tone_select, .quick_retrain_allow, .pcs_loopback,
  .negotiation_enable, .negotiation_restart, .xnp_active, .adv_next_page_able, .bank_reset_pulse);

// ### tb_phy_mmd_registers.sv
/* Bench for the register bank; the host model makes every access.
   Status inputs are driven here on the rising edge. */
`timescale 1ns/1ps
module tb_phy_mmd_registers;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr, wr_data, rd_data;
  logic [4:0] mmd_sel;
  logic [5:0] evt = 6'h00;
  logic [6:0] lv = 7'h00;
  logic [5:0] bo = 6'h3a;
  logic [5:0] pm = 6'h2b;
  logic [20:0] sk = 21'h0aad4b;
  logic wr_stb, rd_stb, rd_valid, quick_retrain_allow, pcs_loopback;
  logic negotiation_enable, negotiation_restart, xnp_active, bank_reset_pulse;
  logic [2:0] transmitter_test_select, test_tone_select;
  logic [1:0] retrain_signal_kind;
  int error_cnt = 0;
  int compares = 0;
  logic [36:0] tab [0:8] = '{{5'h01, 16'h000b, 16'h41a0}, {5'h01, 16'h0015, 16'h0001},
    {5'h03, 16'h0004, 16'h0040}, {5'h03, 16'h0014, 16'h0006}, {5'h03, 16'h0015, 16'h0001},
    {5'h01, 16'h0050, 16'h0000}, {5'h03, 16'h0016, 16'h0000}, {5'h01, 16'h0093, 16'h0011},
    {5'h07, 16'h0000, 16'h2000}};
  always #50 clk_sys = ~clk_sys;
  phy_mmd_registers phy_mmd_registers_i (.clk_sys, .rst, .mmd_sel, .reg_addr, .wr_data, .wr_stb, .rd_stb,
    .rd_data, .rd_valid, .partner_info_live(evt[5]), .partner_backoff_code(bo[5:3]),
    .local_backoff_code(bo[2:0]), .polarity_flags(pm[5:2]), .mdi_connection(pm[1:0]),
    .skew_b(sk[20:14]), .skew_c(sk[13:7]), .skew_d(sk[6:0]), .partner_retrain_evt(evt[0]),
    .local_retrain_evt(evt[1]), .quick_retrain_agreed(lv[0]), .tx_lpi_live(evt[4]), .rx_lpi_live(lv[1]),
    .pcs_link_live(lv[2]), .wake_fault_evt(evt[2]), .page_rx_evt(evt[3]), .negotiation_done(lv[3]),
    .remote_fault_live(lv[4]), .an_link_live(lv[5]), .adv_next_page_able(lv[6]), .transmitter_test_select,
    .test_tone_select, .retrain_signal_kind, .quick_retrain_allow, .pcs_loopback, .negotiation_enable,
    .negotiation_restart, .xnp_active, .bank_reset_pulse);
  mgmt_host mgmt_host_i (.clk_sys, .mmd_sel, .reg_addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .rd_valid);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [4:0] d, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] r;
    mgmt_host_i.rd(d, a, r);
    chk(r, exp);
  endtask
  task automatic pulse(input logic [5:0] m, input int n);
    repeat (n) begin
      @(posedge clk_sys) evt <= m;
      @(posedge clk_sys) evt <= 6'h00;
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (tab[i]) rc(tab[i][36:32], tab[i][31:16], tab[i][15:0]);
    repeat (2) begin
      @(posedge clk_sys) {bo, pm, sk} <= ~{bo, pm, sk};
      #1;
      rc(5'h01, 16'h0083, {bo, 10'h000});
      rc(5'h01, 16'h0082, {4'h0, pm[5:2], 6'h00, pm[1:0]});
      rc(5'h01, 16'h0091, {1'b0, sk[20:14], 8'h00});
      rc(5'h01, 16'h0092, {1'b0, sk[6:0], 1'b0, sk[13:7]});
    end
    for (int m = 0; m < 8; m++) begin
      mgmt_host_i.wr(5'h01, 16'h0084, {m[2:0], 3'h1, 10'h000});
      chk({13'h0, transmitter_test_select}, {13'h0, m[2:0]});
      chk({13'h0, test_tone_select}, (m == 4) ? 16'h0001 : 16'h0000);
    end
    for (int f = 0; f < 8; f++) begin
      mgmt_host_i.wr(5'h01, 16'h0084, {3'h4, f[2:0], 10'h000});
      chk({13'h0, test_tone_select}, (f == 0 || f == 3 || f == 7) ? 16'h0000 : {13'h0, f[2:0]});
    end
    rc(5'h01, 16'h0084, 16'h9c00);
    @(posedge clk_sys) lv <= 7'h01;
    pulse(6'h01, 3);
    // 33 local events show the 5-bit wrap
    pulse(6'h02, 33);
    mgmt_host_i.wr(5'h01, 16'h0093, 16'h0004);
    chk({13'h0, retrain_signal_kind, quick_retrain_allow}, 16'h0004);
    rc(5'h01, 16'h0093, 16'h185c);
    pulse(6'h10, 1);
    rc(5'h03, 16'h0001, 16'h0800);
    rc(5'h03, 16'h0001, 16'h0000);
    @(posedge clk_sys) lv <= 7'h07;
    rc(5'h03, 16'h0001, 16'h0500);
    rc(5'h03, 16'h0001, 16'h0504);
    @(posedge clk_sys) lv <= 7'h03;
    @(posedge clk_sys) lv <= 7'h07;
    rc(5'h03, 16'h0001, 16'h0500);
    rc(5'h03, 16'h0001, 16'h0504);
    pulse(6'h04, 2);
    rc(5'h03, 16'h0016, 16'h0002);
    rc(5'h03, 16'h0016, 16'h0000);
    @(posedge clk_sys) lv <= 7'h3f;
    pulse(6'h08, 1);
    rc(5'h07, 16'h0001, 16'h0078);
    rc(5'h07, 16'h0001, 16'h003c);
    pulse(6'h20, 1);
    rc(5'h01, 16'h0081, 16'h0000);
    mgmt_host_i.wr(5'h01, 16'h8000, 16'h0001);
    pulse(6'h20, 1);
    rc(5'h01, 16'h0081, 16'h0001);
    rc(5'h01, 16'h0081, 16'h0000);
    @(posedge clk_sys) lv <= 7'h7f;
    #1;
    chk({15'h0, xnp_active}, 16'h0001);
    mgmt_host_i.wr(5'h07, 16'h0000, 16'h1200);
    chk({14'h0, negotiation_enable, xnp_active}, 16'h0002);
    chk({15'h0, negotiation_restart}, 16'h0001);
    @(posedge clk_sys) #1;
    chk({15'h0, negotiation_restart}, 16'h0000);
    rc(5'h07, 16'h0000, 16'h1000);
    mgmt_host_i.wr(5'h03, 16'h0000, 16'h4000);
    rc(5'h03, 16'h0000, 16'h605c);
    mgmt_host_i.wr(5'h03, 16'h0000, 16'hc000);
    chk({13'h0, pcs_loopback, negotiation_enable, quick_retrain_allow}, 16'h0001);
    chk({15'h0, bank_reset_pulse}, 16'h0001);
    rc(5'h07, 16'h0000, 16'h2000);
    rc(5'h01, 16'h0093, 16'h0019);
    mgmt_host_i.wr(5'h01, 16'h0084, 16'h2000);
    pulse(6'h04, 1);
    mgmt_host_i.wr(5'h07, 16'h0000, 16'h9000);
    chk({15'h0, negotiation_enable}, 16'h0000);
    rc(5'h01, 16'h0084, 16'h0000);
    rc(5'h03, 16'h0016, 16'h0000);
    print_verdict;
  end
endmodule
